// ==== shared/lhr_defs.vh ====
`ifndef LHR_DEFS_VH
`define LHR_DEFS_VH

// ==========================================================
// Register offsets
`define LHR_ADDR_CONFIG        8'h49
`define LHR_ADDR_TARGET        8'h4A
`define LHR_ADDR_MEASURED      8'h4B

// ==========================================================
// Configuration field positions
`define LHR_MODE_LSB           0
`define LHR_MODE_MSB           2
`define LHR_ISEL_LSB           3
`define LHR_ISEL_MSB           4
`define LHR_OFF_LSB            5
`define LHR_OFF_MSB            7

// ==========================================================
// Reset values
`define LHR_CONFIG_RST         8'h00
`define LHR_TARGET_RST         8'h00
`define LHR_MEASURED_RST       8'h00

// ==========================================================
// Heating modes
`define LHR_MODE_DISABLED      3'h0
`define LHR_MODE_REGULATE      3'h1
`define LHR_MODE_MONITOR       3'h2
`define LHR_MODE_PULSED_ON     3'h4
`define LHR_MODE_FULL_ON       3'h5

// ==========================================================
// Timing
`define LHR_CLK_MHZ            40
`define LHR_SETTLE_NS          1000
`define LHR_SETTLE_CYC         ((`LHR_SETTLE_NS * `LHR_CLK_MHZ + 999) / 1000)
`define LHR_OFF_BASE_US        10
`define LHR_OFF_BASE_CYC       (`LHR_OFF_BASE_US * `LHR_CLK_MHZ)

`endif

// ==== hw/lhr_heater.v ====
`timescale 1ns/10ps
`include "lhr_defs.vh"

module lhr_heater #(
    parameter integer SETTLE_CYC   = `LHR_SETTLE_CYC,
    parameter integer OFF_BASE_CYC = `LHR_OFF_BASE_CYC
) (
    input  wire       core_clk_in,
    input  wire       rst_n_in,
    input  wire [7:0] reg_addr_in,
    input  wire       reg_wr_in,
    input  wire [7:0] reg_wdata_in,
    output reg  [7:0] reg_rdata_out,
    input  wire       cmp_elem_high_in,
    output reg        ref_current_en_out,
    output reg  [1:0] ref_current_sel_out,
    output reg  [7:0] dac_code_out,
    output reg        heater_switch_out,
    output reg        measure_done_out
);

    // ==========================================================
    // Sequencer states
    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_SETTLE = 2'h1;
    localparam [1:0] ST_OFF    = 2'h2;

    // ==========================================================
    // Registers
    reg  [7:0]  config_r;
    reg  [7:0]  target_r;
    reg  [7:0]  measured_r;
    reg  [1:0]  state_r;
    reg  [2:0]  bit_r;
    reg  [7:0]  sar_r;
    // Wide enough for the longest idle at the default base
    reg  [23:0] cnt_r;

    // ==========================================================
    // Configuration decode
    wire [2:0]  mode     = config_r[`LHR_MODE_MSB:`LHR_MODE_LSB];
    wire [2:0]  off_code = config_r[`LHR_OFF_MSB:`LHR_OFF_LSB];
    // Reserved modes fall through to no measurement and no heating
    wire        measuring_mode = (mode == `LHR_MODE_REGULATE) ||
                                 (mode == `LHR_MODE_MONITOR) ||
                                 (mode == `LHR_MODE_PULSED_ON);
    // Doubling per code keeps the idle time strictly increasing
    wire [23:0] off_cyc  = OFF_BASE_CYC[23:0] << off_code;
    wire        in_pulse = (state_r == ST_SETTLE);

    // Comparator read on the last cycle of a window, once the DAC has settled
    wire        window_end = (cnt_r == SETTLE_CYC[23:0] - 24'h000001);
    // Live off field: a shorter code cuts the current idle at once
    wire        off_end    = (cnt_r >= off_cyc - 24'h000001);
    wire        last_bit   = (bit_r == 3'h0);

    // ==========================================================
    // Register write port
    // Writes to the measured code or unmapped offsets are dropped
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            config_r <= `LHR_CONFIG_RST;
            target_r <= `LHR_TARGET_RST;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == `LHR_ADDR_CONFIG)
                config_r <= reg_wdata_in;
            if (reg_addr_in == `LHR_ADDR_TARGET)
                target_r <= reg_wdata_in;
        end
    end

    // ==========================================================
    // Register read port
    // Registered read; unmapped addresses return zero
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            reg_rdata_out <= 8'h00;
        else
        begin
            case (reg_addr_in)
                `LHR_ADDR_CONFIG:   reg_rdata_out <= config_r;
                `LHR_ADDR_TARGET:   reg_rdata_out <= target_r;
                `LHR_ADDR_MEASURED: reg_rdata_out <= measured_r;
                default:            reg_rdata_out <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Measurement sequencer: one SAR bit per settle window
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // No pulse runs until a measuring mode is set
            state_r          <= ST_IDLE;
            bit_r            <= 3'h7;
            sar_r            <= 8'h00;
            cnt_r            <= 24'h000000;
            measured_r       <= `LHR_MEASURED_RST;
            measure_done_out <= 1'b0;
        end
        else
        begin
            // Done is a single-cycle strobe
            measure_done_out <= 1'b0;
            if (!measuring_mode)
            begin
                // Pulse dropped; measured code keeps its last value
                state_r <= ST_IDLE;
                cnt_r   <= 24'h000000;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        // Every pulse restarts from the mid-scale MSB trial
                        state_r <= ST_SETTLE;
                        bit_r   <= 3'h7;
                        sar_r   <= 8'h80;
                        cnt_r   <= 24'h000000;
                    end
                    ST_SETTLE:
                    begin
                        if (window_end)
                        begin
                            cnt_r <= 24'h000000;
                            // Element higher than DAC point: keep the trial bit
                            if (!cmp_elem_high_in)
                                sar_r[bit_r] <= 1'b0;
                            // LSB decided here; one update per completed pulse
                            if (last_bit)
                            begin
                                measured_r       <= cmp_elem_high_in ? sar_r
                                                    : (sar_r & 8'hFE);
                                measure_done_out <= 1'b1;
                                state_r          <= ST_OFF;
                            end
                            else
                            begin
                                // Next lower bit becomes the trial
                                bit_r             <= bit_r - 3'h1;
                                sar_r[bit_r - 3'h1] <= 1'b1;
                            end
                        end
                        else
                            cnt_r <= cnt_r + 24'h000001;
                    end
                    ST_OFF:
                    begin
                        // Reference current stays off for the whole idle
                        if (off_end)
                            state_r <= ST_IDLE;
                        else
                            cnt_r <= cnt_r + 24'h000001;
                    end
                    default:
                        state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // Analog drive and heater switch
    always @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ref_current_en_out  <= 1'b0;
            ref_current_sel_out <= 2'h0;
            dac_code_out        <= 8'h00;
            heater_switch_out   <= 1'b0;
        end
        else
        begin
            // Current and switch change on one edge, so they never overlap
            ref_current_en_out  <= measuring_mode && (state_r == ST_SETTLE);
            ref_current_sel_out <= config_r[`LHR_ISEL_MSB:`LHR_ISEL_LSB];
            // DAC follows the trial word one edge later
            dac_code_out        <= sar_r;
            case (mode)
                // Released during pulses so heating current cannot skew the reading
                `LHR_MODE_REGULATE:
                    heater_switch_out <= !in_pulse && (measured_r < target_r);
                `LHR_MODE_MONITOR:
                    heater_switch_out <= 1'b0;
                `LHR_MODE_PULSED_ON:
                    heater_switch_out <= !in_pulse;
                `LHR_MODE_FULL_ON:
                    heater_switch_out <= 1'b1;
                // Reserved codes land here and heat nothing
                default:
                    heater_switch_out <= 1'b0;
            endcase
        end
    end

endmodule

// ==== verification/lhr_elem_model.sv ====
`timescale 1ns/10ps
module lhr_elem_model (
    input  wire        core_clk_in,
    input  wire        ref_current_en_in,
    input  wire  [7:0] dac_code_in,
    input  wire  [7:0] elem_code_in,
    output logic       cmp_elem_high_out
);
    logic tgl_r = 1'b0;
    // Without current the comparator output is meaningless, so it wanders
    always @(posedge core_clk_in) tgl_r <= ~tgl_r;
    assign cmp_elem_high_out = ref_current_en_in ? (elem_code_in >= dac_code_in) : tgl_r;
endmodule

// ==== verification/lhr_heater_assertions.sv ====
`timescale 1ns/10ps
module lhr_heater_assertions #(
    parameter integer SETTLE_CYC   = 40,
    parameter integer OFF_BASE_CYC = 400
) (
    input wire       core_clk_in,
    input wire       rst_n_in,
    input wire [7:0] reg_addr_in,
    input wire       reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire [7:0] reg_rdata_out,
    input wire       cmp_elem_high_in,
    input wire       ref_current_en_out,
    input wire [1:0] ref_current_sel_out,
    input wire [7:0] dac_code_out,
    input wire       heater_switch_out,
    input wire       measure_done_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ==========================================
    // Shadow of the configuration register
    logic [7:0] cfg_r;
    int         len_r;
    wire  [2:0] mode = cfg_r[2:0];
    wire        meas = (mode == 3'h1) || (mode == 3'h2) || (mode == 3'h4);
    always @(posedge core_clk_in or negedge rst_n_in)
        if (!rst_n_in)
        begin
            cfg_r <= 8'h00;
            len_r <= 0;
        end
        else
        begin
            if (reg_wr_in && reg_addr_in == 8'h49) cfg_r <= reg_wdata_in;
            len_r <= ref_current_en_out ? len_r + 1 : 0;
        end
    // ==========================================
    // Properties
    property p_sel; $stable(cfg_r) |-> ref_current_sel_out == cfg_r[4:3]; endproperty
    a_sel: assert property (p_sel) else $error("current select wrong");
    property p_off; (!meas)[*3] |-> !ref_current_en_out; endproperty
    a_off: assert property (p_off) else $error("current on without measuring");
    property p_full; (mode == 3'h5)[*3] |-> heater_switch_out; endproperty
    a_full: assert property (p_full) else $error("switch not on");
    property p_mon; (mode == 3'h2 || mode == 3'h0)[*2] |-> !heater_switch_out; endproperty
    a_mon: assert property (p_mon) else $error("switch on while off mode");
    property p_pls; (mode == 3'h4)[*3] ##0 $stable(ref_current_en_out)
        |-> heater_switch_out != ref_current_en_out; endproperty
    a_pls: assert property (p_pls) else $error("pulsed switch wrong");
    property p_reg; (mode == 3'h1)[*3] ##0 ref_current_en_out[*2] |-> !heater_switch_out;
    endproperty
    a_reg: assert property (p_reg) else $error("switch on in pulse");
    property p_len; $fell(ref_current_en_out) && meas && $stable(cfg_r)
        |-> len_r == 8 * SETTLE_CYC; endproperty
    a_len: assert property (p_len) else $error("pulse length wrong");
    property p_done; measure_done_out |=> !measure_done_out; endproperty
    a_done: assert property (p_done) else $error("done too long");
    c_done: cover property (measure_done_out);
    c_reg: cover property (mode == 3'h1 && heater_switch_out);
    c_pls: cover property (mode == 3'h4 && heater_switch_out);
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/10ps
module tb;
    logic       clk, rst_n, wr, cmp, ref_en, sw, done;
    logic [1:0] sel;
    logic [7:0] addr, wdata, rdata, dac, elem, v;
    int         failures, num_checks, cyc, g0, g3;
    lhr_heater #(.SETTLE_CYC(2), .OFF_BASE_CYC(4)) lhr_heater_inst (
        .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .cmp_elem_high_in(cmp),
        .ref_current_en_out(ref_en), .ref_current_sel_out(sel), .dac_code_out(dac),
        .heater_switch_out(sw), .measure_done_out(done));
    lhr_elem_model lhr_elem_model_inst (.core_clk_in(clk), .ref_current_en_in(ref_en),
        .dac_code_in(dac), .elem_code_in(elem), .cmp_elem_high_out(cmp));
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ==========================================
    // Access tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= 8'h03;
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        addr <= 8'h03;
        #1 chk(rdata, exp);
    endtask
    task wait_done;
        int n;
        n = 0;
        do begin @(posedge clk); #1 n++; end while (done !== 1'b1 && n < 400);
        if (n >= 400) chk(8'h00, 8'h01);
    endtask
    task final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #(25 * 20000);
        failures++;
        final_report;
    end
    // ==========================================
    // Tests
    initial
    begin
        rst_n = 0; wr = 0; addr = 8'h00; wdata = 8'h00; elem = 8'h80;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rchk(8'h49, 8'h00);
        chk({sw, ref_en}, 8'h00);
        wr8(8'h4B, 8'h55);
        rchk(8'h4B, 8'h00);
        rchk(8'h03, 8'h00);
        wr8(8'h49, 8'h18);
        repeat (30) @(posedge clk);
        rchk(8'h49, 8'h18);
        chk(sel, 8'h03);
        wr8(8'h49, 8'h0A);
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : (i == 2) ? 8'hFF : 8'h5C;
            elem <= v;
            wait_done; wait_done;
            rchk(8'h4B, v);
            chk(dac, v);
            chk(sw, 1'b0);
        end
        wr8(8'h4A, 8'h90);
        rchk(8'h4A, 8'h90);
        elem <= 8'h80;
        wr8(8'h49, 8'h61);
        wait_done; wait_done; repeat (2) @(posedge clk);
        #1 chk(sw, 1'b1);
        elem <= 8'h90;
        wait_done; wait_done; repeat (2) @(posedge clk);
        #1 chk(sw, 1'b0);
        wr8(8'h49, 8'h64);
        wait_done; repeat (2) @(posedge clk);
        #1 chk(sw, 1'b1);
        wr8(8'h49, 8'h05);
        repeat (5) @(posedge clk);
        #1 chk({sw, ref_en}, 8'h02);
        wr8(8'h49, 8'h02);
        wait_done; g0 = cyc; wait_done; g0 = cyc - g0;
        wr8(8'h49, 8'h62);
        wait_done; g3 = cyc; wait_done; g3 = cyc - g3;
        chk(8'(g0), 8'h15);
        chk(8'(g3 - g0), 8'h1C);
        final_report;
    end
endmodule
bind lhr_heater lhr_heater_assertions #(.SETTLE_CYC(SETTLE_CYC), .OFF_BASE_CYC(OFF_BASE_CYC))
    lhr_heater_assertions_inst (.core_clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in,
    .reg_wdata_in, .reg_rdata_out, .cmp_elem_high_in, .ref_current_en_out,
    .ref_current_sel_out, .dac_code_out, .heater_switch_out, .measure_done_out);
